// file: logic/ied_pkg.sv
`default_nettype none
package ied_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] IED_OFS_BASE = 8'h00;
  localparam logic [7:0] IED_OFS_SP = 8'h04;
  localparam logic [7:0] IED_OFS_PSW = 8'h08;
  localparam logic [7:0] IED_OFS_VEC = 8'h0C;
  localparam logic [7:0] IED_OFS_ISTAT = 8'h10;
  localparam logic [7:0] IED_OFS_IMASK = 8'h14;
  localparam logic [7:0] IED_OFS_STATE = 8'h18;
  // status word bit positions
  localparam int IED_PSW_T = 1;
  localparam int IED_PSW_P = 2;
  localparam int IED_PSW_E = 9;
  localparam int IED_PSW_I = 11;
  // reset values
  localparam logic [15:0] IED_SP_RST = 16'h0000;
  localparam logic [15:0] IED_PSW_RST = 16'h0000;
  localparam logic [20:0] IED_BASE_RST = 21'h000000;
  // writable bits of the table base: bits 15..1
  localparam logic [20:0] IED_BASE_WMASK = 21'h00FFFE;
  // stack frame step and word step
  localparam logic [15:0] IED_FRAME = 16'h0004;
  localparam logic [15:0] IED_WORD = 16'h0002;
  // vector positions
  localparam logic [5:0] IED_VEC_NMI = 6'h01;
  localparam logic [5:0] IED_VEC_MASK0 = 6'h10;
  localparam logic [5:0] IED_VEC_LAST = 6'h2F;
  // own event bits: entry done, return done, nmi taken
  localparam int IED_EV_N = 3;
  localparam int IED_EV_ENTRY = 0;
  localparam int IED_EV_RET = 1;
  localparam int IED_EV_NMI = 2;
  // sequencer states, gray coded along each path except the FETCH to IDLE step
  typedef enum logic [3:0] {
    IED_IDLE = 4'h0,
    IED_DEC = 4'h1,
    IED_PUSH_PC = 4'h3,
    IED_PUSH_PSW = 4'h2,
    IED_VEC = 4'h6,
    IED_FETCH = 4'h7,
    IED_POP_PC = 4'h4,
    IED_POP_PSW = 4'hC,
    IED_INC = 4'h8
  } ied_state_e;
endpackage : ied_pkg
`default_nettype wire

// file: logic/ied_top.sv
// Notes on behaviour
// - On entry, lower the exception stack pointer by four before any store.
// - Then store program counter and status word at the lowered pointer.
// - During entry clear global enable, trace-pending and trace bits.
// - After saving, take the vector number from the vector register.
// - Fetch the table entry at base plus offset and load it as PC.
// - Return reloads PC and status word from stack, raises pointer by four.
// - Each table entry is two bytes holding address bits 1 to 16.
// - Handler address is zero, the entry, then zero: 21 bits.
// - Table base is 21 bits, top five bits and bit 0 stay zero.
// - The table spans 48 word entries.
// - Entry address is the vector doubled plus the table base.
// - Positions 0 to 15 are traps and nmi at 1; request n at 16+n.
// - The periodic tick request 31 uses the last position, 47.
// - Nmi comes from a falling edge on its pin and ranks highest.
// - Timer, serial, wake-up and converter requests are all maskable.
// - Maskable requests are levels, request 31 highest, request 0 lowest.
// - Highest pending maskable request goes first, others wait.
// - No maskable request is taken unless global and local enables are set.
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`default_nettype none
module ied_top
  import ied_pkg::*;
#(
  parameter int NUM_IRQ = 32
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // requests
  input wire logic nmi_n,
  input wire logic [NUM_IRQ-1:0] maskable_request_n,
  // core side
  input wire logic [20:0] core_pc,
  input wire logic return_from_exception,
  output logic pc_load,
  output logic [20:0] pc_value,
  output logic entry_busy,
  // memory master for stack and table
  output logic mem_req,
  output logic mem_we,
  output logic [20:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  // interrupt to system
  output logic irq
);

  typedef struct packed {
    ied_state_e st;
    logic [15:0] exception_stack_pointer, processor_status_word;
    logic [20:0] dispatch_table_base;
    logic [5:0] vector_number_reg;
    logic [15:0] saved_pc;
    logic nmi_prev, nmi_pend;
    logic mem_req, mem_we;
    logic [20:0] mem_addr;
    logic [15:0] mem_wdata;
    logic pc_load;
    logic [20:0] pc_value;
    logic busy, ack;
    logic [31:0] rdata;
    logic [IED_EV_N-1:0] stat, mask;
    logic irq;
  } ied_regs_s;
  ied_regs_s r;
  ied_regs_s n;
  // highest set request index, request 31 first
  function automatic logic [4:0] ied_prio(input logic [31:0] req);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 0; i < 32; i++)
    begin
      if (req[i])
        idx = 5'(i);
    end
    return idx;
  endfunction : ied_prio

  // byte lane merge for register writes
  function automatic logic [31:0] ied_merge(input logic [31:0] old,
    input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        res[b*8 +: 8] = dat[b*8 +: 8];
    end
    return res;
  endfunction : ied_merge
  logic [31:0] req_all, cur, merged;
  logic mask_ok, nmi_edge, wr_en;
  logic [IED_EV_N-1:0] ev;

  // next state of the whole block, with maskable gating and nmi edge
  always_comb
  begin
    req_all = 32'(maskable_request_n);
    mask_ok = r.processor_status_word[IED_PSW_I]
      && r.processor_status_word[IED_PSW_E] && (|req_all);
    nmi_edge = r.nmi_prev && !nmi_n;
    n = r;
    ev = '0;
    n.pc_load = 1'b0;
    n.nmi_prev = nmi_n;
    // sequencer
    case (r.st)
      IED_IDLE:
      begin
        if (r.nmi_pend || mask_ok)
        begin
          n.saved_pc = core_pc[16:1];
          n.st = IED_DEC;
        end
        else if (return_from_exception)
          n.st = IED_POP_PC;
      end
      IED_DEC:
      begin
        n.exception_stack_pointer = r.exception_stack_pointer
          - IED_FRAME;
        n.st = IED_PUSH_PC;
      end
      IED_PUSH_PC:
      begin
        if (!r.mem_req)
        begin
          n.mem_req = 1'b1;
          n.mem_we = 1'b1;
          n.mem_addr = {5'h00, r.exception_stack_pointer};
          n.mem_wdata = r.saved_pc;
        end
        else if (mem_ack)
        begin
          n.mem_req = 1'b0;
          n.st = IED_PUSH_PSW;
        end
      end
      IED_PUSH_PSW:
      begin
        if (!r.mem_req)
        begin
          n.mem_req = 1'b1;
          n.mem_we = 1'b1;
          n.mem_addr = {5'h00, 16'(r.exception_stack_pointer
            + IED_WORD)};
          n.mem_wdata = r.processor_status_word;
        end
        else if (mem_ack)
        begin
          n.mem_req = 1'b0;
          n.processor_status_word[IED_PSW_I] = 1'b0;
          n.processor_status_word[IED_PSW_P] = 1'b0;
          n.processor_status_word[IED_PSW_T] = 1'b0;
          n.st = IED_VEC;
        end
      end
      IED_VEC:
      begin
        // nmi outranks all maskable requests
        if (r.nmi_pend)
        begin
          n.vector_number_reg = IED_VEC_NMI;
          n.nmi_pend = 1'b0;
          ev[IED_EV_NMI] = 1'b1;
        end
        else
          n.vector_number_reg = IED_VEC_MASK0
            + {1'b0, ied_prio(req_all)};
        n.st = IED_FETCH;
      end
      IED_FETCH:
      begin
        if (!r.mem_req)
        begin
          n.mem_req = 1'b1;
          n.mem_we = 1'b0;
          n.mem_addr = r.dispatch_table_base
            + {14'h0000, r.vector_number_reg, 1'b0};
        end
        else if (mem_ack)
        begin
          n.mem_req = 1'b0;
          n.pc_value = {3'h0, 1'b0, mem_rdata, 1'b0};
          n.pc_load = 1'b1;
          ev[IED_EV_ENTRY] = 1'b1;
          n.st = IED_IDLE;
        end
      end
      IED_POP_PC:
      begin
        if (!r.mem_req)
        begin
          n.mem_req = 1'b1;
          n.mem_we = 1'b0;
          n.mem_addr = {5'h00, r.exception_stack_pointer};
        end
        else if (mem_ack)
        begin
          n.mem_req = 1'b0;
          n.saved_pc = mem_rdata;
          n.st = IED_POP_PSW;
        end
      end
      IED_POP_PSW:
      begin
        if (!r.mem_req)
        begin
          n.mem_req = 1'b1;
          n.mem_we = 1'b0;
          n.mem_addr = {5'h00, 16'(r.exception_stack_pointer + IED_WORD)};
        end
        else if (mem_ack)
        begin
          n.mem_req = 1'b0;
          n.processor_status_word = mem_rdata;
          n.st = IED_INC;
        end
      end
      IED_INC:
      begin
        n.exception_stack_pointer = r.exception_stack_pointer
          + IED_FRAME;
        n.pc_value = {3'h0, 1'b0, r.saved_pc, 1'b0};
        n.pc_load = 1'b1;
        ev[IED_EV_RET] = 1'b1;
        n.st = IED_IDLE;
      end
      default:
      begin
        n.st = IED_IDLE;
        n.mem_req = 1'b0;
      end
    endcase
    n.busy = (n.st != IED_IDLE);
    // bus slave: one-cycle ack, write applied at the ack edge
    n.ack = wb_cyc_i && wb_stb_i && !r.ack;
    wr_en = n.ack && wb_we_i;
    cur = 32'h00000000;
    case (wb_adr_i)
      IED_OFS_BASE: cur = {11'h000, r.dispatch_table_base};
      IED_OFS_SP: cur = {16'h0000, r.exception_stack_pointer};
      IED_OFS_PSW: cur = {16'h0000, r.processor_status_word};
      IED_OFS_VEC: cur = {26'h0000000, r.vector_number_reg};
      IED_OFS_ISTAT: cur = {29'h00000000, r.stat};
      IED_OFS_IMASK: cur = {29'h00000000, r.mask};
      IED_OFS_STATE: cur = {26'h0000000, r.nmi_pend, r.busy, r.st};
      default: cur = 32'h00000000;
    endcase
    if (n.ack && !wb_we_i)
      n.rdata = cur;
    merged = ied_merge(cur, wb_dat_i, wb_sel_i);
    // the sequencer owns pointer and status word while busy
    if (wr_en)
    begin
      case (wb_adr_i)
        IED_OFS_BASE:
          n.dispatch_table_base = merged[20:0] & IED_BASE_WMASK;
        IED_OFS_SP:
          if (!r.busy)
            n.exception_stack_pointer = merged[15:0];
        IED_OFS_PSW:
          if (!r.busy)
            n.processor_status_word = merged[15:0];
        IED_OFS_ISTAT:
          n.stat = r.stat & ~(wb_dat_i[IED_EV_N-1:0]
            & {IED_EV_N{wb_sel_i[0]}});
        IED_OFS_IMASK: n.mask = merged[IED_EV_N-1:0];
        default: n.mask = r.mask;
      endcase
    end
    // events win over a clear in the same cycle
    n.stat = n.stat | ev;
    // nmi edge wins over the clear at vector time
    if (nmi_edge)
      n.nmi_pend = 1'b1;
    n.irq = |(n.stat & n.mask);
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.st <= IED_IDLE;
      r.exception_stack_pointer <= IED_SP_RST;
      r.processor_status_word <= IED_PSW_RST;
      r.dispatch_table_base <= IED_BASE_RST;
      r.nmi_prev <= 1'b1;
    end
    else
      r <= n;
  end

  // outputs straight from the state
  assign wb_dat_o = r.rdata;
  assign wb_ack_o = r.ack;
  assign pc_load = r.pc_load;
  assign pc_value = r.pc_value;
  assign entry_busy = r.busy;
  assign mem_req = r.mem_req;
  assign mem_we = r.mem_we;
  assign mem_addr = r.mem_addr;
  assign mem_wdata = r.mem_wdata;
  assign irq = r.irq;

  default clocking ied_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_sp_lowered:
    assert property (r.st == IED_DEC |=> r.st == IED_PUSH_PC
      && r.exception_stack_pointer == $past(r.exception_stack_pointer)
      - IED_FRAME)
    else $error("stack pointer not lowered by four");
  a_push_at_sp:
    assert property (r.st == IED_PUSH_PC && r.mem_req |-> r.mem_we
      && r.mem_addr == {5'h00, r.exception_stack_pointer})
    else $error("program counter not stored at stack pointer");
  a_psw_cleared:
    assert property (r.st == IED_PUSH_PSW && r.mem_req && mem_ack |=>
      !r.processor_status_word[IED_PSW_I]
      && !r.processor_status_word[IED_PSW_P]
      && !r.processor_status_word[IED_PSW_T])
    else $error("status bits not cleared on entry");
  a_nmi_vector:
    assert property (r.st == IED_VEC && r.nmi_pend |=>
      r.vector_number_reg == IED_VEC_NMI)
    else $error("nmi vector not chosen");
  a_fetch_addr:
    assert property (r.st == IED_FETCH && r.mem_req |-> !r.mem_we
      && r.mem_addr == r.dispatch_table_base
      + {14'h0000, r.vector_number_reg, 1'b0})
    else $error("table entry address wrong");
  a_pc_shape:
    assert property (r.pc_load |-> r.pc_value[0] == 1'b0
      && r.pc_value[20:17] == 4'h0 ##1 !r.pc_load)
    else $error("handler address malformed");
  a_sp_raised:
    assert property (r.st == IED_INC |=> r.pc_load
      && r.exception_stack_pointer == $past(r.exception_stack_pointer)
      + IED_FRAME)
    else $error("stack pointer not raised by four");
  a_mask_block:
    assert property (r.st == IED_IDLE && !r.nmi_pend && !nmi_edge
      && !return_from_exception && !r.processor_status_word[IED_PSW_I]
      |=> r.st == IED_IDLE)
    else $error("maskable request taken while disabled");
  a_base_fixed:
    assert property ((r.dispatch_table_base & ~IED_BASE_WMASK) == '0)
    else $error("table base fixed bits set");
  a_vec_range:
    assert property (r.vector_number_reg <= IED_VEC_LAST)
    else $error("vector beyond table");

endmodule : ied_top
`default_nettype wire

// file: tb/ied_mem_model.sv
`default_nettype none
module ied_mem_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // word port from the block
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [20:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  // extra wait cycles per access
  input wire logic [3:0] wait_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:255];
  logic [3:0] cnt;
  // answer a held request after wait_n cycles with a one-cycle ack
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= 16'hA5A5;
    end
    else if (mem_req && !mem_ack && cnt == wait_n)
    begin
      mem_ack <= 1'b1;
      cnt <= 4'h0;
      if (mem_we)
        mem[mem_addr[8:1]] <= mem_wdata;
      else
        mem_rdata <= mem[mem_addr[8:1]];
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata; // read data is gone outside the ack
      if (mem_req && !mem_ack)
        cnt <= cnt + 4'h1;
    end
  end
endmodule : ied_mem_model
`default_nettype wire

// file: tb/ied_top_tb.sv
`default_nettype none
module ied_top_tb import ied_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  logic nmi_n = 1'b1;
  logic [31:0] req = 32'h0;
  logic [20:0] core_pc = 21'h012346;
  logic ret = 1'b0;
  logic pc_load, entry_busy, irq, mem_req, mem_we, mem_ack;
  logic [20:0] pc_value;
  logic [20:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic [3:0] wait_n = 4'h0;
  int err_count = 0;
  int checked = 0;
  int busy;

  // free-running clock
  initial
    forever #20 clk = ~clk;

  ied_top dut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .nmi_n(nmi_n),
    .maskable_request_n(req), .core_pc(core_pc),
    .return_from_exception(ret), .pc_load(pc_load),
    .pc_value(pc_value), .entry_busy(entry_busy), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq(irq)
  );

  ied_mem_model mdl (
    .clk(clk), .rst_n(rst_n), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .wait_n(wait_n)
  );

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic timeout();
    err_count++;
    $display("[ERR] t=%0t wait ran out got=0 exp=1", $time);
    give_verdict();
  endtask : timeout

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one classic wishbone cycle, held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    for (n = 0; n < 20 && ack !== 1'b1; n++)
      @(posedge clk);
    if (ack !== 1'b1)
      timeout();
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk(q, exp);
  endtask : rd

  // wait for the next pc load and compare the new pc
  task automatic wait_load(input logic [20:0] exp);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pc_load !== 1'b1 && n < 100);
    if (pc_load !== 1'b1)
      timeout();
    chk(32'(pc_value), 32'(exp));
  endtask : wait_load

  function automatic logic [20:0] hnd(input logic [5:0] v);
    return {4'h0, 16'h1000 + {10'h000, v}, 1'b0};
  endfunction : hnd

  // main sequence
  initial
  begin
    for (int v = 0; v < 48; v++)
      mdl.mem[128 + v] = 16'h1000 + 16'(v);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(IED_OFS_SP, 32'h0);
    rd(IED_OFS_PSW, 32'h0);
    rd(IED_OFS_BASE, 32'h0);
    rd(8'h1C, 32'h0);
    rd(IED_OFS_STATE, 32'h0);
    $display("test reset done");
    wr(IED_OFS_BASE, 32'hFFFFFFFF);
    rd(IED_OFS_BASE, 32'h0000FFFE);
    xfer(1'b1, IED_OFS_BASE, 32'h00000000, 4'h1);
    rd(IED_OFS_BASE, 32'h0000FF00);
    wr(IED_OFS_BASE, 32'h00000100);
    wr(IED_OFS_SP, 32'h00000080);
    wr(IED_OFS_PSW, 32'h00000A06);
    $display("test setup done");
    // two requests at once, the higher one goes first
    req <= 32'h80000020;
    wait_load(hnd(6'h2F));
    req <= 32'h00000020;
    rd(IED_OFS_SP, 32'h0000007C);
    chk(32'(mdl.mem[62]), 32'(core_pc[16:1]));
    chk(32'(mdl.mem[63]), 32'h00000A06);
    rd(IED_OFS_PSW, 32'h00000200);
    rd(IED_OFS_VEC, 32'h0000002F);
    rd(IED_OFS_ISTAT, 32'h00000001);
    chk(32'(irq), 32'h0);
    wr(IED_OFS_IMASK, 32'h00000001);
    chk(32'(irq), 32'h1);
    wr(IED_OFS_ISTAT, 32'h00000001);
    rd(IED_OFS_ISTAT, 32'h0);
    chk(32'(irq), 32'h0);
    $display("test entry done");
    // return, then the waiting request is taken
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    wait_load({4'h0, core_pc[16:1], 1'b0});
    wait_load(hnd(6'h15));
    rd(IED_OFS_SP, 32'h0000007C);
    $display("test return done");
    // either enable clear blocks the pending request
    for (int i = 0; i < 2; i++)
    begin
      wr(IED_OFS_PSW, i ? 32'h00000200 : 32'h00000800);
      busy = 0;
      repeat (20) @(posedge clk) busy += int'(entry_busy === 1'b1);
      chk(32'(busy), 32'h0);
    end
    $display("test mask done");
    // nmi edge with a slow memory
    wait_n <= 4'h2;
    nmi_n <= 1'b0;
    wait_load(hnd(IED_VEC_NMI));
    rd(IED_OFS_SP, 32'h00000078);
    rd(IED_OFS_ISTAT, 32'h00000007);
    $display("test nmi done");
    give_verdict();
  end
endmodule : ied_top_tb
`default_nettype wire
